// ===== logic/ssm_defines.vh
// register offsets, field positions, state codes and reset values
`ifndef SSM_DEFINES_VH
`define SSM_DEFINES_VH
// register byte offsets
`define SSM_REG_CMD 6'h00
`define SSM_REG_CTRL 6'h04
`define SSM_REG_STAT 6'h08
`define SSM_REG_VIOL 6'h0c
`define SSM_REG_HINIT 6'h10
`define SSM_REG_HCNT 6'h14
`define SSM_REG_TIME 6'h18
`define SSM_REG_ALARM 6'h1c
`define SSM_REG_KEY 6'h20
`define SSM_REG_STATE 6'h24
// command bits (write-only pulses)
`define SSM_CMD_TRANS 0
`define SSM_CMD_FATAL 1
`define SSM_CMD_NONFATAL 2
`define SSM_CMD_HLOAD 3
`define SSM_CMD_HCLEAR 4
`define SSM_CMD_HLOCK 5
`define SSM_CMD_RSTART 6
`define SSM_CMD_RSTOP 7
`define SSM_CMD_KPROG 8
// control fields
`define SSM_CTL_HEN 0
`define SSM_CTL_HRUN 1
`define SSM_CTL_AIE 2
`define SSM_CTL_PIE 3
`define SSM_CTL_CALEN 4
`define SSM_CTL_CAL_LO 8
`define SSM_CTL_CAL_HI 12
`define SSM_CTL_RATE_LO 16
`define SSM_CTL_RATE_HI 19
`define SSM_CTL_KSEL 20
// status fields
`define SSM_ST_ALARM 0
`define SSM_ST_PER 1
`define SSM_ST_EKZERO 2
`define SSM_ST_FKZERO 3
`define SSM_ST_RUN 4
`define SSM_ST_LOCK 5
// violation fields
`define SSM_SV_LOWPWR 0
`define SSM_SV_ECC 1
`define SSM_SV_LOWPWR_SW 2
`define SSM_SV_FATAL 3
`define SSM_SV_SW 4
`define SSM_SV_NUM_LO 8
`define SSM_SV_NUM_HI 12
// reset values
`define SSM_CAL_RST 5'h00
`define SSM_RATE_RST 4'h0
// state codes
`define SSM_ST_INIT 3'h0
`define SSM_ST_HFAIL 3'h1
`define SSM_ST_SFAIL 3'h2
`define SSM_ST_INTER 3'h3
`define SSM_ST_CHECK 3'h4
`define SSM_ST_NSEC 3'h5
`define SSM_ST_TRUST 3'h6
`define SSM_ST_SEC 3'h7
`endif

// ===== logic/ssm_flag.v
// sticky status flag: hardware set wins over software clear
`timescale 1ns/1ps
module ssm_flag (
  input wire core_clk,
  input wire sys_rst,
  input wire set_in,
  input wire clr_in,
  output reg flag_reg
);
  // a set in the clear cycle is kept so no event is lost
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      flag_reg <= 1'b0;
    end else if (set_in) begin
      flag_reg <= 1'b1;
    end else if (clr_in) begin
      flag_reg <= 1'b0;
    end
  end
endmodule // ssm_flag

// ===== logic/ssm_monitor.v
// security state monitor: state machine, assurance counter, clock, flags
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ps
`include "ssm_defines.vh"
// Function
// - eight security states, current state readable by software
// - trigger in check goes non-secure on non-secure boot outside fab
// - trigger in check goes trusted on secure boot or fab config
// - trigger swaps trusted/secure, soft fail to non-secure, else nothing
// - fatal software violation sends functional states to soft fail
// - enabled counter cleared in soft fail gives hard fail at once
// - enabled counter cleared in functional state: soft then hard fail
// - counter holds initial value; load copies it; count readable
// - counter has separate enable and start/stop controls
// - lock freezes initial value and enable until system reset
// - time counter counts only when started; time readable and writable
// - alarm and periodic interrupts with enables and clearable flags
// - report all listed security violation flags
// - master key selection enable and erasable key program trigger
// - reset: calibration off, calibration zero, periodic rate zero
// - non-fatal violation: check to non-secure, trusted/secure to soft fail
// - calibration is 5-bit signed, used only when enabled
// - periodic rate selector takes values 0 to 15
module ssm_monitor #(
  parameter ASC_W = 32,
  parameter KEY_W = 32,
  parameter TICK_DIV = 16'd1526
) (
  input wire core_clk,
  input wire sys_rst,
  input wire [5:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire boot_secure,
  input wire fab_config,
  input wire lowpwr_violation,
  input wire lowpwr_sw_violation,
  input wire key_ecc_fail,
  input wire [4:0] num_violation,
  input wire [KEY_W-1:0] fused_master_key,
  output reg [2:0] ssm_state_reg,
  output reg alarm_irq_reg,
  output reg periodic_irq_reg,
  output reg key_select_en_reg,
  output reg [KEY_W-1:0] erasable_master_key_reg
);
  reg [31:0] ctrl_reg;
  reg [ASC_W-1:0] asc_init_reg;
  reg [ASC_W-1:0] asc_cnt_reg;
  reg asc_lock_reg;
  reg [31:0] rtc_time_reg;
  reg [31:0] rtc_alarm_reg;
  reg rtc_run_reg;
  reg [15:0] div_reg;
  reg [KEY_W-1:0] key_stage_reg;
  reg ekzero_reg;
  reg fkzero_reg;
  reg [2:0] ssm_state_next;
  wire wr_cmd;
  wire [31:0] cmd;
  wire asc_en;
  wire asc_run;
  wire cal_en;
  wire [4:0] cal_val;
  wire [3:0] rate;
  wire functional;
  wire [15:0] div_period;
  wire tick;
  wire [31:0] rtc_inc;
  wire alarm_hit;
  wire per_hit;
  wire wr_stat;
  wire wr_viol;
  wire alarm_flag;
  wire per_flag;
  wire [9:0] viol_flags;
  wire [9:0] viol_set;
  wire [9:0] viol_clr;
  genvar gi;

  // command register strobes are one-cycle pulses
  assign wr_cmd = reg_wr && (reg_addr == `SSM_REG_CMD);
  assign cmd = wr_cmd ? reg_wdata : 32'h00000000;
  assign asc_en = ctrl_reg[`SSM_CTL_HEN];
  assign asc_run = ctrl_reg[`SSM_CTL_HRUN];
  assign cal_en = ctrl_reg[`SSM_CTL_CALEN];
  assign cal_val = ctrl_reg[`SSM_CTL_CAL_HI:`SSM_CTL_CAL_LO];
  assign rate = ctrl_reg[`SSM_CTL_RATE_HI:`SSM_CTL_RATE_LO];
  assign functional = (ssm_state_reg == `SSM_ST_CHECK) ||
                      (ssm_state_reg == `SSM_ST_NSEC) ||
                      (ssm_state_reg == `SSM_ST_TRUST) ||
                      (ssm_state_reg == `SSM_ST_SEC);

  // control register; lock shields the counter enable bit
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_reg <= 32'h00000000;
    end else if (reg_wr && (reg_addr == `SSM_REG_CTRL)) begin
      ctrl_reg <= reg_wdata;
      if (asc_lock_reg) begin
        ctrl_reg[`SSM_CTL_HEN] <= ctrl_reg[`SSM_CTL_HEN];
      end
    end
  end

  // lock is sticky; only the system reset releases it
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      asc_lock_reg <= 1'b0;
    end else if (cmd[`SSM_CMD_HLOCK]) begin
      asc_lock_reg <= 1'b1;
    end
  end

  // initial value register, frozen after lock
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      asc_init_reg <= {ASC_W{1'b0}};
    end else if (reg_wr && (reg_addr == `SSM_REG_HINIT) &&
                 !asc_lock_reg) begin
      asc_init_reg <= reg_wdata[ASC_W-1:0];
    end
  end

  // assurance counter: load, clear, count down in soft fail while started
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      asc_cnt_reg <= {ASC_W{1'b0}};
    end else if (cmd[`SSM_CMD_HCLEAR]) begin
      asc_cnt_reg <= {ASC_W{1'b0}};
    end else if (cmd[`SSM_CMD_HLOAD]) begin
      asc_cnt_reg <= asc_init_reg;
    end else if (asc_en && asc_run && (asc_cnt_reg != {ASC_W{1'b0}}) &&
                 (ssm_state_reg == `SSM_ST_SFAIL)) begin
      asc_cnt_reg <= asc_cnt_reg - {{(ASC_W-1){1'b0}}, 1'b1};
    end
  end

  // state machine; fatal and counter events outrank software triggers
  always @* begin
    ssm_state_next = ssm_state_reg;
    case (ssm_state_reg)
      `SSM_ST_INIT: begin
        ssm_state_next = `SSM_ST_INTER;
      end
      `SSM_ST_INTER: begin
        ssm_state_next = `SSM_ST_CHECK;
      end
      `SSM_ST_HFAIL: begin
        ssm_state_next = `SSM_ST_HFAIL;
      end
      `SSM_ST_SFAIL: begin
        if (asc_en && (cmd[`SSM_CMD_HCLEAR] ||
            (asc_cnt_reg == {ASC_W{1'b0}}))) begin
          ssm_state_next = `SSM_ST_HFAIL;
        end else if (cmd[`SSM_CMD_TRANS]) begin
          ssm_state_next = `SSM_ST_NSEC;
        end
      end
      `SSM_ST_CHECK: begin
        if (cmd[`SSM_CMD_FATAL] || (asc_en && cmd[`SSM_CMD_HCLEAR])) begin
          ssm_state_next = `SSM_ST_SFAIL;
        end else if (cmd[`SSM_CMD_NONFATAL]) begin
          ssm_state_next = `SSM_ST_NSEC;
        end else if (cmd[`SSM_CMD_TRANS]) begin
          if (boot_secure || fab_config) begin
            ssm_state_next = `SSM_ST_TRUST;
          end else begin
            ssm_state_next = `SSM_ST_NSEC;
          end
        end
      end
      `SSM_ST_NSEC: begin
        if (cmd[`SSM_CMD_FATAL] || (asc_en && cmd[`SSM_CMD_HCLEAR])) begin
          ssm_state_next = `SSM_ST_SFAIL;
        end
      end
      `SSM_ST_TRUST, `SSM_ST_SEC: begin
        if (cmd[`SSM_CMD_FATAL] || cmd[`SSM_CMD_NONFATAL] ||
            (asc_en && cmd[`SSM_CMD_HCLEAR])) begin
          ssm_state_next = `SSM_ST_SFAIL;
        end else if (cmd[`SSM_CMD_TRANS]) begin
          ssm_state_next = (ssm_state_reg == `SSM_ST_TRUST) ?
                           `SSM_ST_SEC : `SSM_ST_TRUST;
        end
      end
      default: begin
        ssm_state_next = `SSM_ST_HFAIL;
      end
    endcase
  end

  // state register, readable through the state register
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ssm_state_reg <= `SSM_ST_INIT;
    end else begin
      ssm_state_reg <= ssm_state_next;
    end
  end

  // tick divider; calibration stretches or shortens the period
  assign div_period = cal_en ?
    (TICK_DIV + {{11{cal_val[4]}}, cal_val}) : TICK_DIV;
  assign tick = rtc_run_reg && (div_reg >= div_period - 16'h0001);

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_reg <= 16'h0000;
    end else if (!rtc_run_reg || tick) begin
      div_reg <= 16'h0000;
    end else begin
      div_reg <= div_reg + 16'h0001;
    end
  end

  // run flag follows start and stop commands
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rtc_run_reg <= 1'b0;
    end else if (cmd[`SSM_CMD_RSTOP]) begin
      rtc_run_reg <= 1'b0;
    end else if (cmd[`SSM_CMD_RSTART]) begin
      rtc_run_reg <= 1'b1;
    end
  end

  assign rtc_inc = rtc_time_reg + 32'h00000001;

  // time counter; a software write wins over a tick
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rtc_time_reg <= 32'h00000000;
    end else if (reg_wr && (reg_addr == `SSM_REG_TIME)) begin
      rtc_time_reg <= reg_wdata;
    end else if (tick) begin
      rtc_time_reg <= rtc_inc;
    end
  end

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rtc_alarm_reg <= 32'h00000000;
    end else if (reg_wr && (reg_addr == `SSM_REG_ALARM)) begin
      rtc_alarm_reg <= reg_wdata;
    end
  end

  // alarm on match while running; periodic on rising edge of chosen bit
  assign alarm_hit = rtc_run_reg && (rtc_time_reg == rtc_alarm_reg);
  assign per_hit = tick && !rtc_time_reg[rate] && rtc_inc[rate];
  assign wr_stat = reg_wr && (reg_addr == `SSM_REG_STAT);
  assign wr_viol = reg_wr && (reg_addr == `SSM_REG_VIOL);

  ssm_flag u_alarm_flag (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .set_in(alarm_hit),
    .clr_in(wr_stat && reg_wdata[`SSM_ST_ALARM]),
    .flag_reg(alarm_flag)
  );

  ssm_flag u_per_flag (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .set_in(per_hit),
    .clr_in(wr_stat && reg_wdata[`SSM_ST_PER]),
    .flag_reg(per_flag)
  );

  // interrupt lines gated by their enables
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      alarm_irq_reg <= 1'b0;
      periodic_irq_reg <= 1'b0;
    end else begin
      alarm_irq_reg <= alarm_flag && ctrl_reg[`SSM_CTL_AIE];
      periodic_irq_reg <= per_flag && ctrl_reg[`SSM_CTL_PIE];
    end
  end

  // violation sources: low power, ecc, low power sw, fatal sw, sw, numbered
  assign viol_set = {num_violation, cmd[`SSM_CMD_NONFATAL],
                     cmd[`SSM_CMD_FATAL], lowpwr_sw_violation, key_ecc_fail,
                     lowpwr_violation};
  // only ecc and numbered flags may be cleared by software
  assign viol_clr = wr_viol ? {reg_wdata[`SSM_SV_NUM_HI:`SSM_SV_NUM_LO],
                               3'h0, reg_wdata[`SSM_SV_ECC], 1'b0} : 10'h000;

  generate
    for (gi = 0; gi < 10; gi = gi + 1) begin : g_viol
      ssm_flag u_viol (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .set_in(viol_set[gi]),
        .clr_in(viol_clr[gi]),
        .flag_reg(viol_flags[gi])
      );
    end
  endgenerate

  // staged key value copied to the erasable key on the program trigger
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      key_stage_reg <= {KEY_W{1'b0}};
      erasable_master_key_reg <= {KEY_W{1'b0}};
      key_select_en_reg <= 1'b0;
    end else begin
      if (reg_wr && (reg_addr == `SSM_REG_KEY)) begin
        key_stage_reg <= reg_wdata[KEY_W-1:0];
      end
      if (cmd[`SSM_CMD_KPROG]) begin
        erasable_master_key_reg <= key_stage_reg;
      end
      key_select_en_reg <= ctrl_reg[`SSM_CTL_KSEL];
    end
  end

  // zero detectors are registered to keep the compare off the read path
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ekzero_reg <= 1'b0;
      fkzero_reg <= 1'b0;
    end else begin
      ekzero_reg <= (erasable_master_key_reg == {KEY_W{1'b0}});
      fkzero_reg <= (fused_master_key == {KEY_W{1'b0}});
    end
  end

  // read data valid only in the cycle after the read strobe
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        `SSM_REG_CTRL: reg_rdata <= ctrl_reg;
        `SSM_REG_STAT: reg_rdata <= {26'h0000000, asc_lock_reg,
                                     rtc_run_reg, fkzero_reg, ekzero_reg,
                                     per_flag, alarm_flag};
        `SSM_REG_VIOL: reg_rdata <= {19'h00000, viol_flags[9:5], 3'h0,
                                     viol_flags[4:0]};
        `SSM_REG_HINIT: reg_rdata <= asc_init_reg;
        `SSM_REG_HCNT: reg_rdata <= asc_cnt_reg;
        `SSM_REG_TIME: reg_rdata <= rtc_time_reg;
        `SSM_REG_ALARM: reg_rdata <= rtc_alarm_reg;
        `SSM_REG_STATE: reg_rdata <= {29'h00000000, ssm_state_reg};
        default: reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end
endmodule // ssm_monitor

// ===== test/ssm_monitor_props.sv
// port assertions for the security state monitor
`timescale 1ns/1ps
`include "ssm_defines.vh"
module ssm_monitor_props #(
  parameter ASC_W = 32,
  parameter KEY_W = 32,
  parameter TICK_DIV = 16'd1526
) (
  input wire core_clk,
  input wire sys_rst,
  input wire [5:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  input wire boot_secure,
  input wire fab_config,
  input wire [2:0] ssm_state_reg,
  input wire key_select_en_reg
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  // single command bits only, so write priority never muddles a check
  wire cmd_wr = reg_wr && (reg_addr == `SSM_REG_CMD);
  wire trig = cmd_wr && (reg_wdata[4:0] == 5'h01);
  wire fatal = cmd_wr && (reg_wdata[4:0] == 5'h02);
  wire nonfatal = cmd_wr && (reg_wdata[4:0] == 5'h04);
  wire ctl_wr = reg_wr && (reg_addr == `SSM_REG_CTRL);
  wire [2:0] st = ssm_state_reg;
  sequence s_boot;
    st == `SSM_ST_INTER ##1 st == `SSM_ST_CHECK;
  endsequence
  sequence s_ctl_once;
    ctl_wr ##1 !ctl_wr;
  endsequence
  a_boot_walk: assert property (
    st == `SSM_ST_INIT && !sys_rst |=> s_boot)
    else $error("boot walk wrong");
  a_trig_nonsecure: assert property (
    trig && st == `SSM_ST_CHECK && !boot_secure && !fab_config
    |=> st == `SSM_ST_NSEC) else $error("trigger in check wrong");
  a_trig_trusted: assert property (
    trig && st == `SSM_ST_CHECK && (boot_secure || fab_config)
    |=> st == `SSM_ST_TRUST) else $error("trigger to trusted wrong");
  a_trig_swap: assert property (
    trig && (st == `SSM_ST_TRUST || st == `SSM_ST_SEC)
    |=> st == ($past(st) ^ 3'h1)) else $error("trusted swap wrong");
  a_trig_ignored: assert property (
    trig && (st == `SSM_ST_NSEC || st == `SSM_ST_HFAIL)
    |=> $stable(st)) else $error("trigger not ignored");
  a_fatal_soft: assert property (
    fatal && st >= `SSM_ST_CHECK |=> st == `SSM_ST_SFAIL)
    else $error("fatal violation wrong");
  a_nonfatal_check: assert property (
    nonfatal && st == `SSM_ST_CHECK |=> st == `SSM_ST_NSEC)
    else $error("non-fatal in check wrong");
  a_nonfatal_fail: assert property (
    nonfatal && st >= `SSM_ST_TRUST |=> st == `SSM_ST_SFAIL)
    else $error("non-fatal in trusted wrong");
  a_state_read: assert property (
    reg_rd && reg_addr == `SSM_REG_STATE
    |=> reg_rdata == {29'h0, $past(st)}) else $error("state read wrong");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data not idle");
  a_key_select: assert property (
    s_ctl_once |=> key_select_en_reg == $past(reg_wdata[20], 2))
    else $error("key select wrong");
endmodule // ssm_monitor_props
bind ssm_monitor ssm_monitor_props #(
  .ASC_W(ASC_W), .KEY_W(KEY_W), .TICK_DIV(TICK_DIV)
) i_props (
  .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .boot_secure(boot_secure),
  .fab_config(fab_config), .ssm_state_reg(ssm_state_reg),
  .key_select_en_reg(key_select_en_reg)
);

// ===== test/ssm_monitor_test.sv
// self-checking bench for the security state monitor
`timescale 1ns/1ps
module ssm_monitor_test;
  reg core_clk, sys_rst, reg_wr, reg_rd, boot_secure, fab_config;
  reg lowpwr_violation, lowpwr_sw_violation, key_ecc_fail;
  reg [5:0] reg_addr;
  reg [31:0] reg_wdata, fused_master_key;
  reg [4:0] num_violation;
  wire [31:0] reg_rdata, erasable_master_key_reg;
  wire [2:0] ssm_state_reg;
  wire alarm_irq_reg, periodic_irq_reg, key_select_en_reg;
  integer mismatches, n_tests, i;
  // short tick so the time tests stay brief
  ssm_monitor #(.TICK_DIV(16'd4)) i_dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .boot_secure(boot_secure),
    .fab_config(fab_config), .lowpwr_violation(lowpwr_violation),
    .lowpwr_sw_violation(lowpwr_sw_violation), .key_ecc_fail(key_ecc_fail),
    .num_violation(num_violation), .fused_master_key(fused_master_key),
    .ssm_state_reg(ssm_state_reg), .alarm_irq_reg(alarm_irq_reg),
    .periodic_irq_reg(periodic_irq_reg),
    .key_select_en_reg(key_select_en_reg),
    .erasable_master_key_reg(erasable_master_key_reg)
  );
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // count every compare, report a difference at once
  task chk(input [31:0] got, input [31:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // strobe lowered at the taking edge; next call waits one more edge
  task wr(input [5:0] a, input [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task rdc(input [5:0] a, input [31:0] m, input [31:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata & m, e);
  endtask
  task sst(input [31:0] e);
    rdc(6'h24, 32'h7, e);
  endtask
  task rst(input bs, input fb);
    @(posedge core_clk);
    sys_rst <= 1'b1;
    boot_secure <= bs;
    fab_config <= fb;
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
  task stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // hang guard: the sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge core_clk);
    mismatches = mismatches + 1;
    stop_test;
  end
  initial begin
    mismatches = 0;
    n_tests = 0;
    sys_rst = 1'b1;
    {reg_wr, reg_rd, boot_secure, fab_config} = 4'h0;
    {lowpwr_violation, lowpwr_sw_violation, key_ecc_fail} = 3'h0;
    reg_addr = 6'h00;
    reg_wdata = 32'h0;
    num_violation = 5'h00;
    fused_master_key = 32'h0;
    rst(1'b0, 1'b0);
    sst(32'h4);
    rdc(6'h04, 32'hffffffff, 32'h0);
    rdc(6'h3c, 32'hffffffff, 32'h0);
    rdc(6'h08, 32'hc, 32'hc);
    $display("defaults test done");
    // non-secure boot walk, trigger refused in non-secure
    wr(6'h00, 32'h1);
    sst(32'h5);
    wr(6'h00, 32'h1);
    sst(32'h5);
    wr(6'h00, 32'h2);
    sst(32'h2);
    rdc(6'h0c, 32'h8, 32'h8);
    wr(6'h00, 32'h1);
    sst(32'h5);
    rst(1'b0, 1'b0);
    wr(6'h00, 32'h4);
    sst(32'h5);
    rdc(6'h0c, 32'h10, 32'h10);
    // secure boot and fab config both lead to trusted
    rst(1'b1, 1'b0);
    wr(6'h00, 32'h1);
    sst(32'h6);
    wr(6'h00, 32'h1);
    sst(32'h7);
    wr(6'h00, 32'h1);
    sst(32'h6);
    wr(6'h00, 32'h4);
    sst(32'h2);
    rst(1'b0, 1'b1);
    wr(6'h00, 32'h1);
    sst(32'h6);
    wr(6'h00, 32'h2);
    sst(32'h2);
    $display("transition test done");
    // clear in check: soft fail, then hard fail one cycle on
    rst(1'b0, 1'b0);
    wr(6'h10, 32'h64);
    wr(6'h04, 32'h1);
    wr(6'h00, 32'h8);
    rdc(6'h14, 32'hffffffff, 32'h64);
    wr(6'h00, 32'h10);
    #1 chk({29'h0, ssm_state_reg}, 32'h2);
    @(posedge core_clk);
    #1 chk({29'h0, ssm_state_reg}, 32'h1);
    // lock freezes initial value and enable, not start
    rst(1'b0, 1'b0);
    wr(6'h10, 32'h64);
    wr(6'h04, 32'h3);
    rdc(6'h04, 32'h3, 32'h3);
    wr(6'h00, 32'h20);
    rdc(6'h08, 32'h20, 32'h20);
    wr(6'h10, 32'h9);
    rdc(6'h10, 32'hffffffff, 32'h64);
    wr(6'h04, 32'h0);
    rdc(6'h04, 32'h3, 32'h1);
    // loaded and stopped count keeps soft fail until the clear
    wr(6'h00, 32'h8);
    wr(6'h00, 32'h2);
    sst(32'h2);
    wr(6'h00, 32'h10);
    #1 chk({29'h0, ssm_state_reg}, 32'h1);
    wr(6'h00, 32'h1);
    sst(32'h1);
    rst(1'b0, 1'b0);
    rdc(6'h08, 32'h20, 32'h0);
    $display("counter test done");
    // field limits, then a stopped and a running clock
    wr(6'h04, 32'h001f100c);
    rdc(6'h04, 32'hffffffff, 32'h001f100c);
    chk({31'h0, key_select_en_reg}, 32'h1);
    wr(6'h04, 32'h0000000c);
    wr(6'h18, 32'h40);
    repeat (20) @(posedge core_clk);
    rdc(6'h18, 32'hffffffff, 32'h40);
    wr(6'h18, 32'h10);
    wr(6'h1c, 32'h12);
    wr(6'h00, 32'h40);
    rdc(6'h08, 32'h10, 32'h10);
    for (i = 0; i < 100 && alarm_irq_reg !== 1'b1; i = i + 1) #20;
    chk({31'h0, alarm_irq_reg}, 32'h1);
    for (i = 0; i < 100 && periodic_irq_reg !== 1'b1; i = i + 1) #20;
    chk({31'h0, periodic_irq_reg}, 32'h1);
    wr(6'h00, 32'h80);
    wr(6'h04, 32'h8);
    @(posedge core_clk);
    #1 chk({31'h0, alarm_irq_reg}, 32'h0);
    rdc(6'h08, 32'h1, 32'h1);
    wr(6'h08, 32'h3);
    rdc(6'h08, 32'h3, 32'h0);
    chk({31'h0, periodic_irq_reg}, 32'h0);
    // calibration +4 doubles the short tick: ticks on every 8th edge
    wr(6'h04, 32'h00000410);
    wr(6'h18, 32'h0);
    wr(6'h00, 32'h40);
    repeat (40) @(posedge core_clk);
    wr(6'h00, 32'h80);
    rdc(6'h18, 32'hffffffff, 32'h5);
    $display("time test done");
    // violation inputs for one cycle; only some flags clear
    rst(1'b0, 1'b0);
    @(posedge core_clk);
    {lowpwr_violation, lowpwr_sw_violation, key_ecc_fail} <= 3'h7;
    num_violation <= 5'h1f;
    @(posedge core_clk);
    {lowpwr_violation, lowpwr_sw_violation, key_ecc_fail} <= 3'h0;
    num_violation <= 5'h00;
    rdc(6'h0c, 32'hffffffff, 32'h00001f07);
    wr(6'h0c, 32'h00001f1f);
    rdc(6'h0c, 32'hffffffff, 32'h00000005);
    // nonzero fused key, erasable key programmed from staging
    @(posedge core_clk);
    fused_master_key <= 32'h00001234;
    wr(6'h20, 32'h0000a5a5);
    rdc(6'h20, 32'hffffffff, 32'h0);
    wr(6'h00, 32'h100);
    @(posedge core_clk);
    #1 chk(erasable_master_key_reg, 32'h0000a5a5);
    rdc(6'h08, 32'hc, 32'h0);
    $display("flag test done");
    stop_test;
  end
endmodule // ssm_monitor_test
